// file: rtl/psc_pkg.sv
// Package of constants and types for the power saving controller.
// Assumes a single core clock domain and a byte-wide register port.
package psc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PSC_ADDR_CONTROL = 8'hdf;
  localparam logic [7:0] PSC_ADDR_STATUS = 8'he8;
  localparam logic [7:0] PSC_CONTROL_RESET = 8'h03;
  localparam int PSC_ENTER_BIT = 7;
  localparam int PSC_STATUS_SAVING_BIT = 1;
  localparam logic [1:0] PSC_MODE_NONE = 2'h0;
  localparam logic [1:0] PSC_MODE_STANDBY = 2'h1;
  localparam logic [1:0] PSC_MODE_SUSPEND = 2'h2;
  localparam logic [1:0] PSC_MODE_SLEEP = 2'h3;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PSC_CLK_PERIOD_NS = 100;
  localparam int PSC_RESUME_NS = 400;
  localparam int PSC_RESUME_CYCLES = (PSC_RESUME_NS + PSC_CLK_PERIOD_NS - 1) / PSC_CLK_PERIOD_NS;
  localparam logic [3:0] PSC_RESUME_COUNT = 4'(PSC_RESUME_CYCLES);
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PSC_NORMAL,
    PSC_SAVING,
    PSC_RESUMING
  } psc_state_e;
  typedef struct packed {
    logic core_clock_en;
    logic pixel_clock_en;
    logic memory_clock_en;
    logic memory_from_osc;
    logic memory_pll_en;
    logic core_pll_en;
  } psc_clk_s;
endpackage

// file: rtl/psc_clk_if.sv
// Interface carrying the clock gate controls from the decoder.
// Assumes both ends sit in the core clock domain.
`timescale 1ns/1ns
`default_nettype none
interface psc_clk_if;
  import psc_pkg::*;
  logic [1:0] mode;
  logic saving;
  psc_clk_s gates;
  modport dec (input mode, input saving, output gates);
  modport top (output mode, output saving, input gates);
endinterface
`default_nettype wire

// file: rtl/psc_clk_decode.sv
// Decodes the power saving mode into clock and PLL enables.
// Assumes the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
module psc_clk_decode (
  psc_clk_if.dec cif
);
  import psc_pkg::*;
  always_comb begin
    cif.gates = '{default: 1'b1};
    cif.gates.memory_from_osc = 1'b0;
    if (cif.saving) begin
      case (cif.mode)
        PSC_MODE_STANDBY: begin
          cif.gates.core_clock_en = 1'b0; // [RULE8]
          cif.gates.pixel_clock_en = 1'b0; // [RULE8]
        end
        PSC_MODE_SUSPEND: begin
          cif.gates.core_clock_en = 1'b0; // [RULE9]
          cif.gates.pixel_clock_en = 1'b0; // [RULE9]
          cif.gates.memory_from_osc = 1'b1; // [RULE9]
          cif.gates.memory_pll_en = 1'b0; // [RULE9]
          cif.gates.core_pll_en = 1'b0;
        end
        PSC_MODE_SLEEP: begin
          cif.gates = '{default: 1'b0}; // [RULE10]
        end
        default: begin
          cif.gates = '{default: 1'b1}; // [RULE11]
          cif.gates.memory_from_osc = 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: rtl/psc_top.sv
// Power saving controller: control register, wake logic, clock gating.
// Assumes a host register port synchronous to core_clk_i; wake inputs synchronous.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// How it works
// RULE1 - Writing one to control bit 7 enters the saving state chosen by the mode field.
// RULE2 - A zero in bit 7 means normal running or a request to return to it.
// RULE3 - An external interrupt, a key scan wake or a software wake ends the saving state.
// RULE4 - Writing zero to bit 7 while saving is the software wake request.
// RULE5 - Bit 7 keeps reading one after a wake request until the chip has resumed.
// RULE6 - The host writes no other register until it sees normal running again.
// RULE7 - Status bit 1 shows saving activity and the host may poll it or bit 7.
// RULE8 - Standby stops the core and pixel clocks and keeps memory on its PLL.
// RULE9 - Suspend stops core and pixel clocks and runs memory from the oscillator.
// RULE10 - Sleep stops every clock and every PLL.
// RULE11 - Mode zero requested for entry leaves the device running normally.
module psc_top (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  input wire logic ext_irq_wake_i,
  input wire logic key_scan_wake_i,
  output logic core_clock_en_o,
  output logic pixel_clock_en_o,
  output logic memory_clock_en_o,
  output logic memory_from_osc_o,
  output logic memory_pll_en_o,
  output logic core_pll_en_o,
  output logic saving_o
);
  import psc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    psc_state_e state;
    logic enter;
    logic [1:0] mode;
    logic [3:0] resume_cnt;
    logic [7:0] rdata;
    psc_clk_s gates;
    logic saving;
  } psc_regs_s;

  localparam psc_regs_s PSC_REGS_RESET = '{
    state: PSC_NORMAL,
    enter: PSC_CONTROL_RESET[PSC_ENTER_BIT],
    mode: PSC_CONTROL_RESET[1:0],
    resume_cnt: '0,
    rdata: '0,
    gates: '{default: 1'b1, memory_from_osc: 1'b0},
    saving: 1'b0
  };

  psc_regs_s r;
  psc_regs_s next_r;
  psc_clk_if cif ();

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  psc_clk_decode u_decode (
    .cif(cif)
  );

  assign cif.mode = r.mode;
  assign cif.saving = (r.state == PSC_SAVING);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.rdata = '0;
    if (reg_read_i) begin
      if (hit(reg_addr_i, PSC_ADDR_CONTROL)) begin
        next_r.rdata = {r.enter, 5'h00, r.mode}; // [RULE5]
      end else if (hit(reg_addr_i, PSC_ADDR_STATUS)) begin
        next_r.rdata[PSC_STATUS_SAVING_BIT] = (r.state != PSC_NORMAL); // [RULE7]
      end
    end
    case (r.state)
      PSC_NORMAL: begin
        if (reg_write_i && hit(reg_addr_i, PSC_ADDR_CONTROL)) begin
          next_r.mode = reg_wdata_i[1:0];
          if (reg_wdata_i[PSC_ENTER_BIT] && reg_wdata_i[1:0] != PSC_MODE_NONE) begin
            next_r.enter = 1'b1; // [RULE1]
            next_r.state = PSC_SAVING;
          end else begin
            next_r.enter = 1'b0; // [RULE2] [RULE11]
          end
        end
      end
      PSC_SAVING: begin
        // Mode is frozen while saving so the gates cannot glitch between modes.
        if (ext_irq_wake_i || key_scan_wake_i ||
            (reg_write_i && hit(reg_addr_i, PSC_ADDR_CONTROL) &&
             !reg_wdata_i[PSC_ENTER_BIT])) begin // [RULE3] [RULE4]
          next_r.state = PSC_RESUMING;
          next_r.resume_cnt = PSC_RESUME_COUNT;
        end
      end
      PSC_RESUMING: begin
        // The host is expected to stay off the bus here, so writes are ignored. [RULE6]
        if (r.resume_cnt <= 4'h1) begin
          next_r.state = PSC_NORMAL;
          next_r.enter = 1'b0; // [RULE5]
          next_r.resume_cnt = '0;
        end else begin
          next_r.resume_cnt = r.resume_cnt - 4'h1;
        end
      end
      default: begin
        next_r.state = PSC_NORMAL;
      end
    endcase
    next_r.gates = cif.gates;
    next_r.saving = (next_r.state != PSC_NORMAL); // [RULE7]
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      r <= PSC_REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o = r.rdata;
  assign core_clock_en_o = r.gates.core_clock_en;
  assign pixel_clock_en_o = r.gates.pixel_clock_en;
  assign memory_clock_en_o = r.gates.memory_clock_en;
  assign memory_from_osc_o = r.gates.memory_from_osc;
  assign memory_pll_en_o = r.gates.memory_pll_en;
  assign core_pll_en_o = r.gates.core_pll_en;
  assign saving_o = r.saving;
endmodule
`default_nettype wire

// file: bench/psc_top_props.sv
// Assertions on the ports of the power saving controller.
// Assumes a bind to psc_top and the register map of psc_pkg.
`timescale 1ns/1ns
`default_nettype none
module psc_top_props
  import psc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic ext_irq_wake_i,
  input wire logic key_scan_wake_i,
  input wire logic core_clock_en_o,
  input wire logic pixel_clock_en_o,
  input wire logic memory_clock_en_o,
  input wire logic memory_from_osc_o,
  input wire logic memory_pll_en_o,
  input wire logic core_pll_en_o,
  input wire logic saving_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  wire ctl = reg_addr_i == PSC_ADDR_CONTROL;
  wire ent = reg_write_i && ctl && reg_wdata_i[7] && !saving_o;
  wire [1:0] md = reg_wdata_i[1:0];
  // A stopped core clock lags the state by one cycle: saving after its first cycle, plus the first resume cycle.
  wire wake = !core_clock_en_o && (ext_irq_wake_i || key_scan_wake_i
    || (reg_write_i && ctl && !reg_wdata_i[7]));
  a_enter_saving: assert property (ent && md != PSC_MODE_NONE |=> saving_o)
    else $error("no saving after entry");
  a_mode_zero: assert property (ent && md == PSC_MODE_NONE |=> !saving_o ##1 core_clock_en_o)
    else $error("mode zero left normal");
  a_standby_gates: assert property (ent && md == PSC_MODE_STANDBY |-> ##2 !core_clock_en_o &&
    !pixel_clock_en_o && memory_clock_en_o && memory_pll_en_o && !memory_from_osc_o)
    else $error("standby gates wrong");
  a_suspend_gates: assert property (ent && md == PSC_MODE_SUSPEND |-> ##2 !core_clock_en_o &&
    !pixel_clock_en_o && memory_clock_en_o && memory_from_osc_o && !memory_pll_en_o)
    else $error("suspend gates wrong");
  a_sleep_gates: assert property (ent && md == PSC_MODE_SLEEP |-> ##2 {core_clock_en_o,
    pixel_clock_en_o, memory_clock_en_o, memory_pll_en_o, core_pll_en_o} == 5'h00)
    else $error("sleep gates wrong");
  a_wake_clocks: assert property (wake |-> ##2 core_clock_en_o && pixel_clock_en_o)
    else $error("wake did not restart clocks");
  a_resume_hold: assert property (wake |-> saving_o [*3] ##[1:8] !saving_o)
    else $error("saving flag timing wrong");
  a_status_bit: assert property (reg_read_i && reg_addr_i == PSC_ADDR_STATUS |=>
    reg_rdata_o[PSC_STATUS_SAVING_BIT] == $past(saving_o)) else $error("status bit wrong");
  a_control_bit: assert property (reg_read_i && ctl |=>
    reg_rdata_o[PSC_ENTER_BIT] == $past(saving_o)) else $error("control bit wrong");
  c_sleep: cover property (ent && md == PSC_MODE_SLEEP);
  c_key_wake: cover property (wake && key_scan_wake_i);
  c_status_set: cover property (reg_read_i && reg_addr_i == PSC_ADDR_STATUS ##1 reg_rdata_o[1]);
endmodule
`default_nettype wire

// file: bench/test_power_saving_controller.sv
// Self-checking bench for the power saving controller.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_power_saving_controller;
  import psc_pkg::*;
  logic core_clk_i = 0, reset_i = 1, reg_write_i = 0, reg_read_i = 0, pend = 0;
  logic ext_irq_wake_i = 0, key_scan_wake_i = 0, saving_o, core_pll_en_o;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
  logic core_clock_en_o, pixel_clock_en_o, memory_clock_en_o, memory_from_osc_o, memory_pll_en_o;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h5b058b5c;
  int errors = 0, n_tests = 0;
  always #50 core_clk_i = ~core_clk_i;
  psc_top DUT (.core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
    .reg_rdata_o, .ext_irq_wake_i, .key_scan_wake_i, .core_clock_en_o, .pixel_clock_en_o,
    .memory_clock_en_o, .memory_from_osc_o, .memory_pll_en_o, .core_pll_en_o, .saving_o);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic op(input logic w, r, input logic [7:0] a, d, input logic x = 0, k = 0);
    @(posedge core_clk_i);
    reg_write_i <= w;
    reg_read_i <= r;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    ext_irq_wake_i <= x;
    key_scan_wake_i <= k;
  endtask
  // Each note holds a mask selecting the bits to compare and the expected byte.
  task automatic rd(input logic [7:0] a, m, e);
    exp_q.push_back({m, e});
    op(0, 1, a, 8'h00);
  endtask
  always @(posedge core_clk_i) pend <= reg_read_i;
  always @(negedge core_clk_i) begin
    if (pend && exp_q.size() > 0) begin
      chk(reg_rdata_o & exp_q[0][15:8], exp_q[0][7:0]);
      void'(exp_q.pop_front());
    end
  end
  initial begin
    int w;
    logic [7:0] a;
    repeat (20) @(posedge core_clk_i);
    reset_i <= 0;
    rd(PSC_ADDR_CONTROL, 8'hff, PSC_CONTROL_RESET);
    for (int m = 1; m < 4; m++) begin
      op(1, 0, PSC_ADDR_CONTROL, 8'h80 | 8'(m));
      op(0, 0, 8'h00, 8'h00);
      rd(PSC_ADDR_CONTROL, 8'h83, 8'h80 | 8'(m));
      rd(PSC_ADDR_STATUS, 8'h02, 8'h02);
      op(m == 3, 0, PSC_ADDR_CONTROL, 8'h00, m == 1, m == 2);
      rd(PSC_ADDR_CONTROL, 8'h80, 8'h80);
      // Only idle cycles until saving_o drops.
      for (w = 0; w < 20 && saving_o !== 1'b0; w++) begin
        op(0, 0, 8'h00, 8'h00);
        #10;
      end
      if (w == 20) begin
        errors++;
        wrap_up();
      end
      rd(PSC_ADDR_CONTROL, 8'h83, 8'(m));
      rd(PSC_ADDR_STATUS, 8'h02, 8'h00);
      $display("mode %0d test done", m);
    end
    op(1, 0, PSC_ADDR_CONTROL, 8'h80);
    op(0, 0, 8'h00, 8'h00);
    rd(PSC_ADDR_CONTROL, 8'h80, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      a = (seed[7:0] inside {PSC_ADDR_CONTROL, PSC_ADDR_STATUS}) ? 8'h00 : seed[7:0];
      op(1, 0, a, seed[15:8]);
      rd(a, 8'hff, 8'h00);
    end
    rd(PSC_ADDR_CONTROL, 8'h83, 8'h00);
    $display("mode zero and unmapped test done");
    repeat (3) op(0, 0, 8'h00, 8'h00);
    wrap_up();
  end
endmodule
bind psc_top psc_top_props u_props (.core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
  .reg_write_i, .reg_read_i, .reg_rdata_o, .ext_irq_wake_i, .key_scan_wake_i, .core_clock_en_o,
  .pixel_clock_en_o, .memory_clock_en_o, .memory_from_osc_o, .memory_pll_en_o, .core_pll_en_o,
  .saving_o);
`default_nettype wire
